// ==== node_consts.vh ====
// constants for the network node state and service gating block
`ifndef NODE_CONSTS_VH
`define NODE_CONSTS_VH
`define CLK_HZ           10000000
`define BOOT_DELAY_MS    5000
`define BOOT_CYCLES      (`BOOT_DELAY_MS * (`CLK_HZ / 1000))
`define SDO_MAX_MS       150
`define SDO_MAX_CYCLES   (`SDO_MAX_MS * (`CLK_HZ / 1000))
`define SDO_TYP_MS       10
`define SDO_TYP_CYCLES   (`SDO_TYP_MS * (`CLK_HZ / 1000))
`define RATE_500K        3'h0
`define RATE_250K        3'h1
`define RATE_125K        3'h2
`define RATE_100K        3'h3
`define RATE_50K         3'h4
`define RATE_20K         3'h5
`define RATE_10K         3'h6
`define TQ_PER_BIT       10
`define NMT_START        8'h01
`define NMT_STOP         8'h02
`define NMT_PREOP        8'h80
`define NMT_RESET_NODE   8'h81
`define NMT_RESET_COMM   8'h82
`define NMT_BROADCAST    7'h00
`define AREA_COMM_LO     16'h1000
`define AREA_COMM_HI     16'h1fff
`define AREA_MFR_LO      16'h2000
`define AREA_MFR_HI      16'h2fff
`define AREA_DEV_LO      16'h6000
`define AREA_DEV_HI      16'h9fff
`define AREA_RSVD_LO     16'ha000
`define AREA_NONE        2'h0
`define AREA_COMM        2'h1
`define AREA_MFR         2'h2
`define AREA_DEV         2'h3
`define PAR_WORDS        4
`endif

// ==== param_store.v ====
// small register memory holding the persistent communication parameters
`default_nettype none
module param_store (
  input  wire       clk,
  input  wire       wrEn,
  input  wire [1:0] wrAddr,
  input  wire [15:0] wrData,
  input  wire [1:0] rdAddr,
  output reg  [15:0] rdData
);
  reg [15:0] mem [0:3];

  always @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// ==== canopen_node.v ====
// network node state machine, service gating and store triggering
//
// Behaviour
// (RL1) bit timing supports 500,250,125,100,50,20,10 kbit/s; no 1M or 800k
// (RL2) frames follow the active 2.0B format, handled by the attached controller
// (RL3) every service request is answered within 150 ms, flagged late otherwise
// (RL4) dictionary entry chosen by 16-bit index, element by 8-bit subindex
// (RL5) index areas: 1000 comm, 2000 maker, 6000-9fff device, a000 up reserved
// (RL6) boot-up message sent about 5 s after power, then pre-operational
// (RL7) pre-operational sends only heartbeat, and only when heartbeat configured
// (RL8) communication parameters written by service requests are stored persistently
// (RL9) start command, broadcast or addressed to this node, makes node operational
// (RL10) operational node sends process data periodically or on sync
// (RL11) services gated by state per the service availability table
// (RL12) data stored on event, timer or command trigger
// (RL13) event store on summary status change while event storing enabled
// (RL14) stop command enters stopped; only management commands accepted there; saveCommand and event_save_enable_command still act in stopped
`default_nettype none
`include "node_consts.vh"
module canopen_node (
  input  wire        clk,
  input  wire        rst,
  input  wire [2:0]  bitRateSel,
  input  wire [6:0]  nodeId,
  input  wire        nmtValid,
  input  wire [7:0]  nmtCommand,
  input  wire [6:0]  nmtTarget,
  input  wire        sdoReqValid,
  input  wire [15:0] sdoIndex,
  input  wire [7:0]  sdoSubindex,
  input  wire        sdoWrite,
  input  wire [15:0] sdoData,
  input  wire        sdoRespDone,
  input  wire        syncValid,
  input  wire        hbTick,
  input  wire        pdoTimerTick,
  input  wire        pdoOnSync,
  input  wire [63:0] statusCode,
  input  wire        saveTimerTick,
  input  wire        saveCommand,
  input  wire        event_save_enable_command,
  input  wire        eventSaveValue,
  output reg  [3:0]  nodeState,
  output reg         bitRateOk,
  output reg  [7:0]  tqPrescale,
  output reg         bootUpTx,
  output reg         heartbeatTx,
  output reg         pdoTx,
  output reg         sdoPending,
  output reg         sdoAccept,
  output reg  [1:0]  sdoArea,
  output reg  [15:0] sdoIndexOut,
  output reg  [7:0]  sdoSubOut,
  output reg         sdoLate,
  output reg  [15:0] heartbeatTime,
  output reg  [15:0] pdoPeriod,
  output reg         storeTx
);
  parameter BOOT_CYCLES = `BOOT_CYCLES;
  parameter SDO_CYCLES  = `SDO_MAX_CYCLES;

  localparam [3:0] ST_INIT  = 4'h1;
  localparam [3:0] ST_PREOP = 4'h2;
  localparam [3:0] ST_OPER  = 4'h4;
  localparam [3:0] ST_STOP  = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // bit rate prescaler for 10 time quanta per bit
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tqPrescale <= 8'h00;
      bitRateOk  <= 1'b0;
    end else begin
      bitRateOk <= 1'b1; // RL1
      case (bitRateSel)
        `RATE_500K: tqPrescale <= 8'h02; // RL1
        `RATE_250K: tqPrescale <= 8'h04;
        `RATE_125K: tqPrescale <= 8'h08;
        `RATE_100K: tqPrescale <= 8'h0a;
        `RATE_50K:  tqPrescale <= 8'h14;
        `RATE_20K:  tqPrescale <= 8'h32;
        `RATE_10K:  tqPrescale <= 8'h64;
        default: begin
          tqPrescale <= 8'h00;
          bitRateOk  <= 1'b0; // RL1
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // node state machine
  reg [3:0]  state_q;
  reg [31:0] bootCnt_q;
  wire       nmtForUs = nmtValid && (nmtTarget == `NMT_BROADCAST || nmtTarget == nodeId); // RL9
  wire       nmtOk = nmtForUs && (state_q != ST_INIT); // RL11

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= ST_INIT;
      bootCnt_q  <= 32'h0;
      bootUpTx   <= 1'b0;
    end else begin
      bootUpTx <= 1'b0;
      case (state_q)
        ST_INIT: begin
          if (bootCnt_q >= BOOT_CYCLES - 1) begin
            bootUpTx  <= 1'b1; // RL6
            state_q   <= ST_PREOP; // RL6
            bootCnt_q <= 32'h0;
          end else begin
            bootCnt_q <= bootCnt_q + 32'h1;
          end
        end
        ST_PREOP, ST_OPER, ST_STOP: begin
          if (nmtOk) begin
            case (nmtCommand)
              `NMT_START:      state_q <= ST_OPER; // RL9
              `NMT_STOP:       state_q <= ST_STOP; // RL14
              `NMT_PREOP:      state_q <= ST_PREOP;
              `NMT_RESET_NODE: state_q <= ST_INIT;
              `NMT_RESET_COMM: state_q <= ST_INIT;
              default:         state_q <= state_q;
            endcase
          end
        end
        default: state_q <= ST_INIT;
      endcase
    end
  end

  always @* begin
    nodeState = state_q;
  end

  wire sdoAllowed  = (state_q == ST_PREOP) || (state_q == ST_OPER); // RL11
  wire syncAllowed = sdoAllowed; // RL11
  wire pdoAllowed  = (state_q == ST_OPER); // RL11

  ////////////////////////////////////////////////////////////////////////////
  // service request tracking and answer deadline
  reg [31:0] sdoCnt_q;
  reg        storeWr;
  reg [1:0]  storeAddr;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sdoPending  <= 1'b0;
      sdoAccept   <= 1'b0;
      sdoArea     <= `AREA_NONE;
      sdoIndexOut <= 16'h0000;
      sdoSubOut   <= 8'h00;
      sdoLate     <= 1'b0;
      sdoCnt_q    <= 32'h0;
    end else begin
      sdoAccept <= 1'b0;
      if (!sdoAllowed) begin
        sdoPending <= 1'b0; // RL14
      end else if (sdoReqValid && !sdoPending) begin
        sdoPending  <= 1'b1;
        sdoAccept   <= 1'b1;
        sdoIndexOut <= sdoIndex; // RL4
        sdoSubOut   <= sdoSubindex; // RL4
        sdoCnt_q    <= 32'h0;
        if (sdoIndex >= `AREA_COMM_LO && sdoIndex <= `AREA_COMM_HI) begin
          sdoArea <= `AREA_COMM; // RL5
        end else if (sdoIndex >= `AREA_MFR_LO && sdoIndex <= `AREA_MFR_HI) begin
          sdoArea <= `AREA_MFR; // RL5
        end else if (sdoIndex >= `AREA_DEV_LO && sdoIndex <= `AREA_DEV_HI) begin
          sdoArea <= `AREA_DEV; // RL5
        end else begin
          sdoArea <= `AREA_NONE; // RL5
        end
      end else if (sdoPending) begin
        if (sdoRespDone) begin
          sdoPending <= 1'b0; // RL3
          sdoLate    <= 1'b0;
        end else if (sdoCnt_q >= SDO_CYCLES - 1) begin
          sdoPending <= 1'b0; // RL3
          sdoLate    <= 1'b1;
        end else begin
          sdoCnt_q <= sdoCnt_q + 32'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // persistent communication parameters
  wire [15:0] paramRd;
  reg  [1:0]  rdPtr_q;

  always @* begin
    storeWr   = sdoReqValid && sdoWrite && sdoAllowed && !sdoPending &&
                (sdoIndex >= `AREA_COMM_LO) && (sdoIndex <= `AREA_COMM_HI); // RL8
    storeAddr = sdoSubindex[1:0];
  end

  param_store u_store (
    .clk    (clk),
    .wrEn   (storeWr),
    .wrAddr (storeAddr),
    .wrData (sdoData),
    .rdAddr (rdPtr_q),
    .rdData (paramRd)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdPtr_q       <= 2'h0;
      heartbeatTime <= 16'h0000;
      pdoPeriod     <= 16'h0000;
    end else begin
      rdPtr_q <= rdPtr_q + 2'h1;
      if (rdPtr_q == 2'h1) begin
        heartbeatTime <= paramRd; // RL8
      end
      if (rdPtr_q == 2'h2) begin
        pdoPeriod <= paramRd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // spontaneous transmissions
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      heartbeatTx <= 1'b0;
      pdoTx       <= 1'b0;
    end else begin
      heartbeatTx <= hbTick && (heartbeatTime != 16'h0000) && (state_q != ST_INIT); // RL7
      pdoTx       <= pdoAllowed && ((pdoOnSync && syncValid && syncAllowed) ||
                                   (!pdoOnSync && pdoTimerTick)); // RL10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement store triggering
  reg [63:0] statusPrev_q;
  reg        eventEn_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      statusPrev_q <= 64'h0;
      eventEn_q    <= 1'b0;
      storeTx      <= 1'b0;
    end else begin
      statusPrev_q <= statusCode;
      if (event_save_enable_command) begin
        eventEn_q <= eventSaveValue; // RL13
      end
      storeTx <= saveTimerTick || saveCommand ||
                 (eventEn_q && (statusCode != statusPrev_q)); // RL12 RL13
    end
  end
endmodule
`default_nettype wire

// ==== canopen_node_assertions.sv ====
// checker for node state and service gating
`default_nettype none
module canopen_node_assertions #(parameter int SDO_CYCLES = 30) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [2:0]  bitRateSel,
  input wire logic [6:0]  nodeId,
  input wire logic        nmtValid,
  input wire logic [7:0]  nmtCommand,
  input wire logic [6:0]  nmtTarget,
  input wire logic        sdoReqValid,
  input wire logic [3:0]  nodeState,
  input wire logic        bitRateOk,
  input wire logic        bootUpTx,
  input wire logic        pdoTx,
  input wire logic        sdoPending,
  input wire logic        sdoAccept,
  input wire logic [1:0]  sdoArea,
  input wire logic [15:0] sdoIndexOut
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] pendCnt_q;
  wire logic   me;
  assign me = nmtValid && !nodeState[0] && (nmtTarget == 7'h00 || nmtTarget == nodeId);
  // cycles the current service request has been open
  always_ff @(posedge clk or posedge rst)
    if (rst) pendCnt_q <= 32'h0;
    else pendCnt_q <= sdoPending ? pendCnt_q + 32'h1 : 32'h0;
  property p_rate; 1'b1 |=> bitRateOk == ($past(bitRateSel) != 3'h7); endproperty
  a_rate: assert property (p_rate) else $error("rate flag");
  property p_acc; sdoReqValid && |nodeState[2:1] && !sdoPending |=> sdoAccept; endproperty
  a_acc: assert property (p_acc) else $error("request not taken");
  property p_start; me && nmtCommand == 8'h01 |=> nodeState == 4'h4; endproperty
  a_start: assert property (p_start) else $error("start ignored");
  property p_stop; me && nmtCommand == 8'h02 |=> nodeState == 4'h8; endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  property p_pdo; pdoTx |-> $past(nodeState) == 4'h4; endproperty
  a_pdo: assert property (p_pdo) else $error("pdo outside oper");
  property p_boot; bootUpTx |-> $past(nodeState) == 4'h1 && nodeState == 4'h2; endproperty
  a_boot: assert property (p_boot) else $error("boot state");
  property p_area; sdoAccept && sdoIndexOut >= 16'ha000 |-> sdoArea == 2'h0; endproperty
  a_area: assert property (p_area) else $error("reserved area");
  property p_late; sdoPending |-> pendCnt_q <= SDO_CYCLES + 1; endproperty
  a_late: assert property (p_late) else $error("request open too long");
endmodule
bind canopen_node canopen_node_assertions #(.SDO_CYCLES(SDO_CYCLES)) chk (.clk, .rst,
  .bitRateSel, .nodeId, .nmtValid, .nmtCommand, .nmtTarget, .sdoReqValid, .nodeState,
  .bitRateOk, .bootUpTx, .pdoTx, .sdoPending, .sdoAccept, .sdoArea, .sdoIndexOut);
`default_nettype wire

// ==== can_master_model.sv ====
// bus master model issuing management and service requests
`default_nettype none
module can_master_model (
  input  wire logic        clk,
  output var  logic        nmtValid,
  output var  logic [7:0]  nmtCommand,
  output var  logic [6:0]  nmtTarget,
  output var  logic        sdoReqValid,
  output var  logic [15:0] sdoIndex,
  output var  logic [7:0]  sdoSubindex,
  output var  logic        sdoWrite,
  output var  logic [15:0] sdoData,
  output var  logic        sdoRespDone
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {nmtValid, nmtCommand, nmtTarget, sdoReqValid, sdoWrite, sdoRespDone} = '0;
    {sdoIndex, sdoSubindex, sdoData} = '0;
  end
  task automatic nmt(input logic [7:0] c, input logic [6:0] t);
    @(negedge clk);
    {nmtValid, nmtCommand, nmtTarget} = {1'b1, c, t};
    @(negedge clk);
    nmtValid = 1'b0;
    {nmtCommand, nmtTarget} = ~{nmtCommand, nmtTarget};
  endtask
  // dly 0: never answered, lets the deadline run out
  task automatic sdo(input logic [15:0] i, input logic [7:0] s, input logic w,
    input logic [15:0] d, input int dly);
    @(negedge clk);
    {sdoReqValid, sdoIndex, sdoSubindex, sdoWrite, sdoData} = {1'b1, i, s, w, d};
    @(negedge clk);
    sdoReqValid = 1'b0;
    {sdoIndex, sdoSubindex, sdoData} = ~{sdoIndex, sdoSubindex, sdoData};
    if (dly > 0) begin
      repeat (dly) @(negedge clk);
      sdoRespDone = 1'b1;
      @(negedge clk);
      sdoRespDone = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== tb_canopen_node.sv ====
// self-checking bench for node state and service gating
`default_nettype none
module tb_canopen_node;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, nmtValid, sdoReqValid, sdoWrite, sdoRespDone, pdoOnSync, eventSaveValue;
  logic bitRateOk, bootUpTx, heartbeatTx, pdoTx, sdoPending, sdoAccept, sdoLate, storeTx;
  wire logic hbTick, pdoTimerTick, syncValid, saveTimerTick, saveCommand;
  wire logic event_save_enable_command;
  logic [5:0] pul;
  logic [2:0] bitRateSel;
  logic [6:0] nodeId, nmtTarget;
  logic [7:0] nmtCommand, sdoSubindex, tqPrescale, sdoSubOut, lastSub, sub;
  logic [15:0] sdoIndex, sdoData, sdoIndexOut, heartbeatTime, pdoPeriod, lastIdx, idx;
  logic [63:0] statusCode;
  logic [3:0] nodeState;
  logic [1:0] sdoArea, lastArea;
  logic [15:0] corner [6] = '{16'h0fff, 16'h1000, 16'h2fff, 16'h6000, 16'h9fff, 16'ha000};
  int fails, total_checks, nAcc, nBoot, nHb, nPdo, nStore, k;
  assign {hbTick, pdoTimerTick, syncValid, saveTimerTick, saveCommand} = pul[5:1];
  assign event_save_enable_command = pul[0];
  canopen_node #(.BOOT_CYCLES(40), .SDO_CYCLES(30)) dut (.clk, .rst, .bitRateSel, .nodeId,
    .nmtValid, .nmtCommand, .nmtTarget, .sdoReqValid, .sdoIndex, .sdoSubindex, .sdoWrite,
    .sdoData, .sdoRespDone, .syncValid, .hbTick, .pdoTimerTick, .pdoOnSync, .statusCode,
    .saveTimerTick, .saveCommand, .event_save_enable_command, .eventSaveValue, .nodeState,
    .bitRateOk, .tqPrescale, .bootUpTx, .heartbeatTx, .pdoTx, .sdoPending, .sdoAccept,
    .sdoArea, .sdoIndexOut, .sdoSubOut, .sdoLate, .heartbeatTime, .pdoPeriod, .storeTx);
  can_master_model master (.clk, .nmtValid, .nmtCommand, .nmtTarget, .sdoReqValid,
    .sdoIndex, .sdoSubindex, .sdoWrite, .sdoData, .sdoRespDone);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    nAcc += (sdoAccept === 1'b1);
    nBoot += (bootUpTx === 1'b1);
    nHb += (heartbeatTx === 1'b1);
    nPdo += (pdoTx === 1'b1);
    nStore += (storeTx === 1'b1);
    if (sdoAccept === 1'b1) begin
      lastArea = sdoArea;
      lastIdx = sdoIndexOut;
      lastSub = sdoSubOut;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic pulse(input logic [5:0] v);
    @(negedge clk);
    pul = v;
    @(negedge clk);
    pul = 6'h0;
    repeat (2) @(negedge clk);
  endtask
  function automatic logic [1:0] area(input logic [15:0] x);
    if (x >= 16'ha000) return 2'h0;
    if (x >= 16'h6000) return 2'h3;
    if (x >= 16'h3000) return 2'h0;
    if (x >= 16'h2000) return 2'h2;
    return (x >= 16'h1000) ? 2'h1 : 2'h0;
  endfunction
  // clocks per quantum: 10 MHz over (bit rate times 10 quanta)
  function automatic logic [7:0] tq(input int r);
    case (r)
      0: return 8'h02;
      1: return 8'h04;
      2: return 8'h08;
      3: return 8'h0a;
      4: return 8'h14;
      5: return 8'h32;
      6: return 8'h64;
      default: return 8'h00;
    endcase
  endfunction
  initial begin
    void'($urandom(32'h3e26));
    {rst, pul, bitRateSel, nodeId, pdoOnSync, statusCode, eventSaveValue} = '0;
    rst = 1'b1;
    nodeId = 7'h15;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    for (k = 0; k < 8; k++) begin
      bitRateSel = k[2:0];
      repeat (2) @(negedge clk);
      chk(bitRateOk, k != 7, "rate");
      chk(tqPrescale, tq(k), "prescale");
    end
    master.sdo(16'h1017, 8'h00, 1'b1, 16'h0005, 0);
    chk(nAcc, 0, "init sdo");
    for (k = 0; k < 100 && nodeState !== 4'h2; k++) @(negedge clk);
    if (k == 100) begin
      fails++;
      conclude();
    end
    @(negedge clk);
    chk(nBoot, 1, "boot");
    pulse(6'h30);
    chk(nHb + nPdo, 0, "quiet preop");
    master.sdo(16'h1017, 8'h00, 1'b1, 16'h0005, 3);
    repeat (8) @(negedge clk);
    chk(heartbeatTime, 16'h0005, "stored");
    pulse(6'h20);
    chk(nHb, 1, "heartbeat");
    for (k = 0; k < 12; k++) begin
      idx = (k < 6) ? corner[k] : 16'($urandom);
      sub = 8'($urandom);
      master.sdo(idx, sub, 1'b0, 16'h0, 1 + $urandom % 4);
      chk(lastSub, sub, "subindex");
      chk(nAcc, k + 2, "accept");
      chk(lastArea, area(idx), "area");
      chk(lastIdx, idx, "index");
    end
    master.nmt(8'h01, nodeId + 7'h1);
    chk(nodeState, 4'h2, "other node");
    master.nmt(8'h01, 7'h00);
    chk(nodeState, 4'h4, "broadcast");
    pulse(6'h10);
    pdoOnSync = 1'b1;
    pulse(6'h08);
    chk(nPdo, 2, "pdo");
    master.nmt(8'h02, nodeId);
    chk(nodeState, 4'h8, "stop");
    master.sdo(16'h1017, 8'h00, 1'b0, 16'h0, 0);
    pulse(6'h18);
    chk(nAcc + nPdo, 15, "stopped quiet");
    master.nmt(8'h80, nodeId);
    chk(nodeState, 4'h2, "preop");
    master.sdo(16'h6000, 8'h00, 1'b0, 16'h0, 0);
    repeat (40) @(negedge clk);
    chk({sdoLate, sdoPending}, 2'b10, "deadline");
    master.sdo(16'h1800, 8'h01, 1'b1, 16'h00c8, 2);
    repeat (8) @(negedge clk);
    chk(pdoPeriod, 16'h00c8, "pdo period");
    pulse(6'h02);
    pulse(6'h04);
    chk(nStore, 2, "command and timer");
    statusCode = {$urandom, $urandom};
    repeat (3) @(negedge clk);
    eventSaveValue = 1'b1;
    pulse(6'h01);
    statusCode = ~statusCode;
    repeat (3) @(negedge clk);
    chk(nStore, 3, "event");
    conclude();
  end
endmodule
`default_nettype wire
